// File: rtl/bera_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a clock enable shared with its user.
module bera_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// A pop frees a slot in the same cycle, so a full store can still requeue
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH)) || (out_ready && out_valid);
	assign out_valid = cnt_q != '0;
	assign out_data  = mem_q[rd_q];
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
			if (push != pop) begin
				cnt_q <= push ? cnt_q + 1'b1 : cnt_q - 1'b1;
			end
		end
	end
endmodule : bera_fifo

// File: rtl/bera_pkg.sv
// Constants for the bit error rate analysis block.
// Assumes a 50 MHz core clock; long counts may be shortened by parameters.
package bera_pkg;
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned MS_PER_SEC    = 1000;
	localparam int unsigned LOSS_WIN_MS   = 1;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_SEC;
	localparam int unsigned LOSS_WIN_CYC  = LOSS_WIN_MS * CYC_PER_MS;
	localparam int unsigned MS_PER_DSEC   = 100;
	localparam int unsigned MS_PER_CSEC   = 10;
	localparam int unsigned UNAVAIL_RUN   = 10;
	localparam int unsigned SEC_PER_BLOCK = 60;
	// Ratio thresholds as bit-count divisors
	localparam int unsigned SES_DIV       = 1000;
	localparam int unsigned DM_DIV        = 1_000_000;
	localparam int unsigned PCT_SCALE     = 100;
	localparam int unsigned STORE_DEPTH   = 8;
	typedef enum logic [1:0] {
		BERA_GRAN_SEC,
		BERA_GRAN_DSEC,
		BERA_GRAN_CSEC,
		BERA_GRAN_MSEC
	} bera_gran_type;
endpackage : bera_pkg

// File: rtl/bera_top.sv
// Error detection and G.821-style error performance analysis.
// Assumes data/clock qualifier from the unit under test are asynchronous.
// What this block does
// - Compare each received bit with reference; mismatch is one error.
// - Separate counts for errored ones, errored zeros and all errors.
// - Total error count accumulates only while gate is active.
// - Delta error count per decisecond, running regardless of gating.
// - Error ratio is gated errors over gated bits received.
// - Delta ratio is interval errors over interval bits.
// - Count errored and error-free intervals at selectable granularity.
// - During gating, judge each powered one-second interval's error ratio.
// - Ten consecutive seconds worse than 1e-3 begin unavailable time, counted so.
// - Ten consecutive seconds better than 1e-3 end it, counted available.
// - Unavailability percent is unavailable seconds over gated seconds.
// - Availability percent is available seconds over gated seconds.
// - Errored seconds percent is errored available over available seconds.
// - Severely errored percent is available seconds worse than 1e-3.
// - Non-severe available seconds in 60 s blocks; worse than 1e-6 degrades.
// - A short trailing block counts as a full block.
// - Count gated power-loss seconds; gating then runs to its set end.
// - Count gated seconds with pattern sync lost, except seconds with power lost.
// - Flag data loss when no data transitions seen for 1 ms.
// - Error entries leave the store once read, unless permanent.
module bera_top
	import bera_pkg::*;
#(
	parameter int unsigned CW         = 32,
	parameter int unsigned CYC_MS     = CYC_PER_MS,
	parameter int unsigned MS_SEC     = MS_PER_SEC,
	parameter int unsigned GATE_SEC   = 60,
	parameter int unsigned ENTRY_W    = 16
) (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               ce,
	input  wire logic               rx_bit_pin,
	input  wire logic               rx_valid_pin,
	input  wire logic               ref_bit,
	input  wire logic               sync_lost,
	input  wire logic               power_lost,
	input  wire logic               gate_start,
	input  wire logic [1:0]         gran_sel,
	output logic                    gating,
	output logic      [CW-1:0]      err_ones,
	output logic      [CW-1:0]      err_zeros,
	output logic      [CW-1:0]      err_total,
	output logic      [CW-1:0]      bits_total,
	output logic      [CW-1:0]      delta_errs,
	output logic      [CW-1:0]      delta_bits,
	output logic      [CW-1:0]      ivl_errored,
	output logic      [CW-1:0]      ivl_clean,
	output logic      [CW-1:0]      sec_gated,
	output logic      [CW-1:0]      sec_unavail,
	output logic      [CW-1:0]      sec_avail,
	output logic      [CW-1:0]      sec_errored,
	output logic      [CW-1:0]      sec_severe,
	output logic      [CW-1:0]      blocks_total,
	output logic      [CW-1:0]      blocks_degraded,
	output logic      [CW-1:0]      sec_power_loss,
	output logic      [CW-1:0]      sec_sync_loss,
	output logic      [6:0]         pct_unavail,
	output logic      [6:0]         pct_avail,
	output logic      [6:0]         pct_errored,
	output logic      [6:0]         pct_severe,
	output logic      [6:0]         pct_degraded,
	output logic                    data_loss,
	input  wire logic               entry_valid,
	input  wire logic               entry_perm,
	input  wire logic [ENTRY_W-1:0] entry_code,
	output logic                    entry_ready,
	output logic                    rd_valid,
	input  wire logic               rd_ack,
	output logic      [ENTRY_W-1:0] rd_code,
	output logic                    rd_perm
);
	// Pin inputs: three stages, change accepted when stages 2 and 3 agree
	logic [2:0] bit_s_q;
	logic [2:0] vld_s_q;
	logic       rx_bit_q;
	logic       rx_vld_q;
	logic       bit_prev_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bit_s_q  <= '0;
			vld_s_q  <= '0;
			rx_bit_q <= 1'b0;
			rx_vld_q <= 1'b0;
		end else if (ce) begin
			bit_s_q <= {bit_s_q[1:0], rx_bit_pin};
			vld_s_q <= {vld_s_q[1:0], rx_valid_pin};
			if (bit_s_q[1] == bit_s_q[2]) begin
				rx_bit_q <= bit_s_q[2];
			end
			if (vld_s_q[1] == vld_s_q[2]) begin
				rx_vld_q <= vld_s_q[2];
			end
		end
	end

	// Bit strobe on rising edge of the settled qualifier
	logic vld_prev_q;
	logic bit_stb;
	logic err_bit;
	logic err_one;
	logic err_zero;

	assign bit_stb  = rx_vld_q && !vld_prev_q;
	assign err_bit  = bit_stb && (rx_bit_q != ref_bit);
	assign err_one  = err_bit && ref_bit;
	assign err_zero = err_bit && !ref_bit;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			vld_prev_q <= 1'b0;
			bit_prev_q <= 1'b0;
		end else if (ce) begin
			vld_prev_q <= rx_vld_q;
			if (bit_stb) begin
				bit_prev_q <= rx_bit_q;
			end
		end
	end

	// Timebase: millisecond tick, then deci/centi/second ticks
	logic [$clog2(CYC_MS)-1:0] cyc_q;
	logic [9:0]                ms_q;
	logic                      ms_tick;
	logic                      cs_tick;
	logic                      ds_tick;
	logic                      s_tick;

	assign ms_tick = cyc_q == ($clog2(CYC_MS))'(CYC_MS - 1);
	assign s_tick  = ms_tick && ms_q == 10'(MS_SEC - 1);
	// Sub-second ticks scale with MS_SEC, so a shortened second keeps its tenths
	localparam int unsigned DS_MS = (MS_SEC * MS_PER_DSEC >= MS_PER_SEC) ?
		MS_SEC * MS_PER_DSEC / MS_PER_SEC : 1;
	localparam int unsigned CS_MS = (MS_SEC * MS_PER_CSEC >= MS_PER_SEC) ?
		MS_SEC * MS_PER_CSEC / MS_PER_SEC : 1;
	assign ds_tick = ms_tick && (ms_q % 10'(DS_MS)) == 10'(DS_MS - 1);
	assign cs_tick = ms_tick && (ms_q % 10'(CS_MS)) == 10'(CS_MS - 1);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cyc_q <= '0;
			ms_q  <= '0;
		end else if (ce) begin
			cyc_q <= ms_tick ? '0 : cyc_q + 1'b1;
			if (ms_tick) begin
				ms_q <= s_tick ? '0 : ms_q + 1'b1;
			end
		end
	end

	// Gate: seconds elapsed even through power loss, so it ends on time
	logic [CW-1:0] gate_left_q;
	logic          gating_q;
	logic          clr;

	assign clr    = gate_start;
	assign gating = gating_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			gating_q    <= 1'b0;
			gate_left_q <= '0;
		end else if (ce) begin
			if (gate_start) begin
				gating_q    <= 1'b1;
				gate_left_q <= CW'(GATE_SEC);
			end else if (gating_q && s_tick) begin
				gate_left_q <= gate_left_q - 1'b1;
				if (gate_left_q == CW'(1)) begin
					gating_q <= 1'b0;
				end
			end
		end
	end

	// Measuring when gated and powered
	logic meas;
	assign meas = gating_q && !power_lost && !gate_start;

	// Gated totals; outputs are the ratio numerators and denominators
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			err_ones   <= '0;
			err_zeros  <= '0;
			err_total  <= '0;
			bits_total <= '0;
		end else if (ce) begin
			if (clr) begin
				err_ones   <= '0;
				err_zeros  <= '0;
				err_total  <= '0;
				bits_total <= '0;
			end else if (meas) begin
				err_ones   <= err_ones + CW'(err_one);
				err_zeros  <= err_zeros + CW'(err_zero);
				err_total  <= err_total + CW'(err_bit);
				bits_total <= bits_total + CW'(bit_stb);
			end
		end
	end

	// Decisecond deltas, free running; latched at each boundary
	logic [CW-1:0] d_err_q;
	logic [CW-1:0] d_bit_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			d_err_q    <= '0;
			d_bit_q    <= '0;
			delta_errs <= '0;
			delta_bits <= '0;
		end else if (ce) begin
			if (ds_tick) begin
				delta_errs <= d_err_q + CW'(err_bit);
				delta_bits <= d_bit_q + CW'(bit_stb);
				d_err_q    <= '0;
				d_bit_q    <= '0;
			end else begin
				d_err_q <= d_err_q + CW'(err_bit);
				d_bit_q <= d_bit_q + CW'(bit_stb);
			end
		end
	end

	// Errored / error-free intervals at the chosen granularity
	logic ivl_tick;
	logic ivl_err_q;

	always_comb begin
		unique case (bera_gran_type'(gran_sel))
			BERA_GRAN_SEC:  ivl_tick = s_tick;
			BERA_GRAN_DSEC: ivl_tick = ds_tick;
			BERA_GRAN_CSEC: ivl_tick = cs_tick;
			BERA_GRAN_MSEC: ivl_tick = ms_tick;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ivl_err_q   <= 1'b0;
			ivl_errored <= '0;
			ivl_clean   <= '0;
		end else if (ce) begin
			if (clr) begin
				ivl_err_q   <= 1'b0;
				ivl_errored <= '0;
				ivl_clean   <= '0;
			end else if (meas) begin
				if (ivl_tick) begin
					ivl_err_q <= 1'b0;
					if (ivl_err_q || err_bit) begin
						ivl_errored <= ivl_errored + 1'b1;
					end else begin
						ivl_clean <= ivl_clean + 1'b1;
					end
				end else if (err_bit) begin
					ivl_err_q <= 1'b1;
				end
			end
		end
	end

	// Per-second error ratio judged by cross-multiplication
	logic [CW-1:0] s_err_q;
	logic [CW-1:0] s_bit_q;
	logic [CW-1:0] s_err;
	logic [CW-1:0] s_bit;
	logic          s_bad;
	logic          s_dm;

	assign s_err = s_err_q + CW'(err_bit);
	assign s_bit = s_bit_q + CW'(bit_stb);
	assign s_bad = (64'(s_err) * 64'(SES_DIV)) > 64'(s_bit);

	// Second accounting with a ten-second run for availability changes
	logic [3:0]    run_q;
	logic          unavail_q;
	logic [CW-1:0] pend_err_q;
	logic [CW-1:0] pend_ses_q;
	logic [CW-1:0] blk_err_q;
	logic [CW-1:0] blk_bit_q;
	logic [5:0]    blk_sec_q;
	logic          flip;
	logic          sec_in;

	assign sec_in = gating_q && !gate_start && s_tick;
	assign flip   = (s_bad != unavail_q) && run_q == 4'(UNAVAIL_RUN - 1);
	assign s_dm   = (64'(blk_err_q) * 64'(DM_DIV)) > 64'(blk_bit_q);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_err_q <= '0;
			s_bit_q <= '0;
		end else if (ce) begin
			if (clr || s_tick) begin
				s_err_q <= '0;
				s_bit_q <= '0;
			end else if (meas) begin
				s_err_q <= s_err;
				s_bit_q <= s_bit;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			run_q          <= '0;
			unavail_q      <= 1'b0;
			pend_err_q     <= '0;
			pend_ses_q     <= '0;
			sec_gated      <= '0;
			sec_unavail    <= '0;
			sec_avail      <= '0;
			sec_errored    <= '0;
			sec_severe     <= '0;
			sec_power_loss <= '0;
			sec_sync_loss  <= '0;
		end else if (ce) begin
			if (clr) begin
				run_q          <= '0;
				unavail_q      <= 1'b0;
				pend_err_q     <= '0;
				pend_ses_q     <= '0;
				sec_gated      <= '0;
				sec_unavail    <= '0;
				sec_avail      <= '0;
				sec_errored    <= '0;
				sec_severe     <= '0;
				sec_power_loss <= '0;
				sec_sync_loss  <= '0;
			end else if (sec_in) begin
				sec_gated <= sec_gated + 1'b1;
				if (power_lost) begin
					sec_power_loss <= sec_power_loss + 1'b1;
				end else begin
					if (sync_lost) begin
						sec_sync_loss <= sec_sync_loss + 1'b1;
					end
					if (s_bad == unavail_q) begin
						// Held run seconds settle into the current state
						run_q      <= '0;
						pend_err_q <= '0;
						pend_ses_q <= '0;
						if (unavail_q) begin
							sec_unavail <= sec_unavail + CW'(run_q) + 1'b1;
						end else begin
							sec_avail   <= sec_avail + CW'(run_q) + 1'b1;
							sec_errored <= sec_errored + pend_err_q + CW'(s_err != '0);
							sec_severe  <= sec_severe + pend_ses_q + CW'(s_bad);
						end
					end else if (flip) begin
						// Whole run changes state and counts on the new side
						unavail_q  <= !unavail_q;
						run_q      <= '0;
						pend_err_q <= '0;
						pend_ses_q <= '0;
						if (unavail_q) begin
							sec_avail   <= sec_avail + CW'(UNAVAIL_RUN);
							sec_errored <= sec_errored + pend_err_q + CW'(s_err != '0);
						end else begin
							sec_unavail <= sec_unavail + CW'(UNAVAIL_RUN);
						end
					end else begin
						run_q      <= run_q + 1'b1;
						pend_err_q <= pend_err_q + CW'(s_err != '0);
						pend_ses_q <= pend_ses_q + CW'(s_bad);
					end
				end
			end
		end
	end

	// Degraded-minute blocks from available non-severe seconds
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			blk_err_q       <= '0;
			blk_bit_q       <= '0;
			blk_sec_q       <= '0;
			blocks_total    <= '0;
			blocks_degraded <= '0;
		end else if (ce) begin
			if (clr) begin
				blk_err_q       <= '0;
				blk_bit_q       <= '0;
				blk_sec_q       <= '0;
				blocks_total    <= '0;
				blocks_degraded <= '0;
			end else if (sec_in && !power_lost && !unavail_q && !s_bad) begin
				if (blk_sec_q == 6'(SEC_PER_BLOCK - 1)) begin
					blk_sec_q <= '0;
					blk_err_q <= '0;
					blk_bit_q <= '0;
				end else begin
					if (blk_sec_q == '0) begin
						blocks_total <= blocks_total + 1'b1;
					end
					blk_sec_q <= blk_sec_q + 1'b1;
					blk_err_q <= blk_err_q + s_err;
					blk_bit_q <= blk_bit_q + s_bit;
				end
			end else if (!gating_q && blk_sec_q != '0) begin
				// Trailing short block judged as a whole block
				blk_sec_q <= '0;
				if (s_dm) begin
					blocks_degraded <= blocks_degraded + 1'b1;
				end
			end
			if (sec_in && !power_lost && !unavail_q && !s_bad &&
				blk_sec_q == 6'(SEC_PER_BLOCK - 1) &&
				(64'(blk_err_q + s_err) * 64'(DM_DIV)) > 64'(blk_bit_q + s_bit)) begin
				blocks_degraded <= blocks_degraded + 1'b1;
			end
		end
	end

	// Percentages, combinational from the counters
	function automatic logic [6:0] pct(input logic [CW-1:0] num, input logic [CW-1:0] den);
		logic [63:0] q;
		q = (den == '0) ? 64'h0 : (64'(num) * 64'(PCT_SCALE)) / 64'(den);
		return q[6:0];
	endfunction : pct

	assign pct_unavail  = pct(sec_unavail, sec_gated);
	assign pct_avail    = pct(sec_avail, sec_gated);
	assign pct_errored  = pct(sec_errored, sec_avail);
	assign pct_severe   = pct(sec_severe, sec_avail);
	assign pct_degraded = pct(blocks_degraded, blocks_total);

	// Loss of transitions over one millisecond
	localparam int unsigned LW = $clog2(LOSS_WIN_MS * CYC_MS + 1);
	logic [LW-1:0] quiet_q;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			quiet_q   <= '0;
			data_loss <= 1'b0;
		end else if (ce) begin
			if (bit_stb && rx_bit_q != bit_prev_q) begin
				quiet_q   <= '0;
				data_loss <= 1'b0;
			end else if (quiet_q == LW'(LOSS_WIN_MS * CYC_MS - 1)) begin
				data_loss <= 1'b1;
			end else begin
				quiet_q <= quiet_q + 1'b1;
			end
		end
	end

	// Error store: reading pops, permanent entries go back in
	logic [ENTRY_W:0] st_out;
	logic             st_valid;
	logic             st_ready;
	logic             st_in_valid;
	logic [ENTRY_W:0] st_in;
	logic             requeue;

	assign requeue     = rd_ack && st_valid && st_out[ENTRY_W];
	assign st_in_valid = requeue || entry_valid;
	assign st_in       = requeue ? st_out : {entry_perm, entry_code};
	assign entry_ready = st_ready && !requeue;
	assign rd_valid    = st_valid;
	assign rd_code     = st_out[ENTRY_W-1:0];
	assign rd_perm     = st_out[ENTRY_W];

	bera_fifo #(
		.WIDTH (ENTRY_W + 1),
		.DEPTH (STORE_DEPTH)
	) u_store (
		.clk       (clk),
		.reset     (reset),
		.ce        (ce),
		.in_valid  (st_in_valid),
		.in_ready  (st_ready),
		.in_data   (st_in),
		.out_valid (st_valid),
		.out_ready (rd_ack),
		.out_data  (st_out)
	);

	property p_data_loss;
		@(posedge clk) disable iff (reset)
		(bit_stb && rx_bit_q != bit_prev_q && ce) |=> !data_loss;
	endproperty
	a_data_loss: assert property (p_data_loss) else $error("data loss set after transition");

	property p_gate_freeze;
		@(posedge clk) disable iff (reset)
		(!gating_q && !gate_start) |=> $stable(err_total);
	endproperty
	a_gate_freeze: assert property (p_gate_freeze) else $error("error count moved outside gate");

	property p_clear;
		@(posedge clk) disable iff (reset)
		(gate_start && ce) |=> (err_total == '0 && sec_gated == '0);
	endproperty
	a_clear: assert property (p_clear) else $error("counters not cleared at gate start");

	property p_split;
		@(posedge clk) disable iff (reset)
		err_total == err_ones + err_zeros;
	endproperty
	a_split: assert property (p_split) else $error("ones plus zeros differ from total");

	property p_secs;
		@(posedge clk) disable iff (reset)
		sec_unavail + sec_avail <= sec_gated;
	endproperty
	a_secs: assert property (p_secs) else $error("state seconds exceed gated seconds");

	property p_perm;
		@(posedge clk) disable iff (reset)
		(requeue && ce) |-> st_ready;
	endproperty
	a_perm: assert property (p_perm) else $error("permanent entry dropped");

	property p_err_bit;
		@(posedge clk) disable iff (reset)
		(ce && meas && err_bit) |=> err_total == $past(err_total) + CW'(1);
	endproperty
	a_err_bit: assert property (p_err_bit) else $error("mismatch not counted");

	property p_severe;
		@(posedge clk) disable iff (reset)
		sec_severe <= sec_avail;
	endproperty
	a_severe: assert property (p_severe) else $error("severe seconds exceed available");
endmodule : bera_top

// File: verif/bera_src.sv
// Serial source model standing in for the unit under test.
// Assumes the bench calls send_bit from a falling clock edge.
module bera_src (
	input  wire logic clk,
	output logic      rx_bit_pin,
	output logic      rx_valid_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_bit_pin   = 1'b0;
		rx_valid_pin = 1'b0;
	end
	// Qualifier held 4 cycles so the synchroniser sees it settled
	task automatic send_bit(input logic b);
		@(negedge clk);
		rx_bit_pin   = b;
		rx_valid_pin = 1'b1;
		repeat (4) @(negedge clk);
		rx_valid_pin = 1'b0;
		repeat (3) @(negedge clk);
		// Stale level is inverted so it never passes for data
		rx_bit_pin = ~b;
	endtask : send_bit
endmodule : bera_src

// File: verif/tb_top.sv
// Self-checking bench for the error analysis block.
// Assumes short second and gate parameters to keep the run brief.
module tb_top
	import bera_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, reset, ce, rx_bit_pin, rx_valid_pin, ref_bit;
	logic        sync_lost, power_lost, gate_start, gating, data_loss;
	logic        entry_valid, entry_perm, entry_ready, rd_valid, rd_ack, rd_perm;
	logic [1:0]  gran_sel;
	logic [15:0] entry_code, rd_code;
	logic [31:0] err_ones, err_zeros, err_total, bits_total;
	logic [31:0] sec_gated, sec_power_loss, sec_sync_loss;
	logic [31:0] delta_errs, delta_bits, ivl_errored, ivl_clean;
	logic [31:0] sec_unavail, sec_avail, sec_errored, sec_severe, blocks_total, blocks_degraded;
	logic [6:0]  pct_unavail, pct_avail, pct_errored, pct_severe, pct_degraded;
	int          error_cnt, tests_run, cyc;

	bera_src u_src (.clk(clk), .rx_bit_pin(rx_bit_pin), .rx_valid_pin(rx_valid_pin));

	bera_top #(.CYC_MS(10), .MS_SEC(20), .GATE_SEC(2)) DUT (
		.clk(clk), .reset(reset), .ce(ce), .rx_bit_pin(rx_bit_pin),
		.rx_valid_pin(rx_valid_pin), .ref_bit(ref_bit), .sync_lost(sync_lost),
		.power_lost(power_lost), .gate_start(gate_start), .gran_sel(gran_sel),
		.gating(gating), .err_ones(err_ones), .err_zeros(err_zeros),
		.err_total(err_total), .bits_total(bits_total), .delta_errs(delta_errs),
		.delta_bits(delta_bits), .ivl_errored(ivl_errored), .ivl_clean(ivl_clean),
		.sec_gated(sec_gated), .sec_unavail(sec_unavail), .sec_avail(sec_avail),
		.sec_errored(sec_errored), .sec_severe(sec_severe), .blocks_total(blocks_total),
		.blocks_degraded(blocks_degraded), .sec_power_loss(sec_power_loss),
		.sec_sync_loss(sec_sync_loss), .pct_unavail(pct_unavail), .pct_avail(pct_avail),
		.pct_errored(pct_errored), .pct_severe(pct_severe), .pct_degraded(pct_degraded),
		.data_loss(data_loss),
		.entry_valid(entry_valid), .entry_perm(entry_perm),
		.entry_code(entry_code), .entry_ready(entry_ready), .rd_valid(rd_valid),
		.rd_ack(rd_ack), .rd_code(rd_code), .rd_perm(rd_perm));

	always #10 clk = ~clk;

	// Ceiling well above the roughly 1200 cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic cmp_cnt(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_cnt

	task automatic cmp_flag(input logic got, input logic exp);
		cmp_cnt({31'h0, got}, {31'h0, exp});
	endtask : cmp_flag

	task automatic put_bit(input logic b, input logic r);
		ref_bit = r;
		u_src.send_bit(b);
	endtask : put_bit

	task automatic start_gate;
		@(negedge clk);
		gate_start = 1'b1;
		@(negedge clk);
		gate_start = 1'b0;
		cmp_flag(gating, 1'b1);
		cmp_cnt(err_total, 32'h0);
		cmp_cnt(bits_total, 32'h0);
	endtask : start_gate

	task automatic wait_end;
		for (int i = 0; i < 800 && gating !== 1'b0; i++) @(negedge clk);
		cmp_flag(gating, 1'b0);
	endtask : wait_end

	task automatic push(input logic [15:0] c, input logic p);
		@(negedge clk);
		entry_code  = c;
		entry_perm  = p;
		entry_valid = 1'b1;
		// Ready judged between edges, never in the accepting edge's time step
		for (int i = 0; i < 20 && entry_ready !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		entry_valid = 1'b0;
	endtask : push

	task automatic pop(input logic [15:0] c, input logic p);
		@(negedge clk);
		cmp_flag(rd_valid, 1'b1);
		cmp_cnt(32'(rd_code), 32'(c));
		cmp_flag(rd_perm, p);
		rd_ack = 1'b1;
		@(negedge clk);
		rd_ack = 1'b0;
	endtask : pop

	task automatic s_errors;
		start_gate();
		put_bit(1'b0, 1'b1);
		put_bit(1'b0, 1'b1);
		put_bit(1'b1, 1'b0);
		put_bit(1'b1, 1'b1);
		put_bit(1'b0, 1'b0);
		repeat (2) @(negedge clk);
		cmp_cnt(err_ones, 32'h2);
		cmp_cnt(err_zeros, 32'h1);
		cmp_cnt(err_total, 32'h3);
		cmp_cnt(bits_total, 32'h5);
		cmp_flag(data_loss, 1'b0);
		// Last closed decisecond held the first three bits, all errored
		cmp_cnt(delta_errs, 32'h3);
		cmp_cnt(delta_bits, 32'h3);
		wait_end();
		cmp_cnt(sec_gated, 32'h2);
		cmp_cnt(ivl_errored, 32'h1);
		cmp_cnt(ivl_clean, 32'h1);
		cmp_cnt(sec_unavail, 32'h0);
		cmp_cnt(sec_avail, 32'h2);
		cmp_cnt(sec_errored, 32'h1);
		cmp_cnt(sec_severe, 32'h1);
		cmp_cnt(32'(pct_unavail), 32'h0);
		cmp_cnt(32'(pct_avail), 32'h64);
		cmp_cnt(32'(pct_errored), 32'h32);
		cmp_cnt(32'(pct_severe), 32'h32);
		put_bit(1'b0, 1'b1);
		repeat (2) @(negedge clk);
		cmp_cnt(err_total, 32'h3);
		cmp_cnt(bits_total, 32'h5);
		cmp_cnt(blocks_total, 32'h1);
		cmp_cnt(blocks_degraded, 32'h0);
		cmp_cnt(32'(pct_degraded), 32'h0);
	endtask : s_errors

	task automatic s_loss_seconds;
		sync_lost = 1'b1;
		gran_sel = BERA_GRAN_MSEC;
		start_gate();
		wait_end();
		sync_lost = 1'b0;
		cmp_cnt(sec_sync_loss, 32'h2);
		// This gate spans 39 quiet millisecond ticks of the free-running timebase
		cmp_cnt(ivl_clean, 32'h27);
		cmp_cnt(ivl_errored, 32'h0);
		power_lost = 1'b1;
		start_gate();
		cmp_cnt(sec_sync_loss, 32'h0);
		wait_end();
		power_lost = 1'b0;
		cmp_cnt(sec_power_loss, 32'h2);
		cmp_cnt(sec_gated, 32'h2);
	endtask : s_loss_seconds

	task automatic s_store;
		push(16'h00A1, 1'b0);
		push(16'h00B2, 1'b1);
		pop(16'h00A1, 1'b0);
		pop(16'h00B2, 1'b1);
		pop(16'h00B2, 1'b1);
		for (int i = 0; i < 7; i++) push(16'h00C0 + 16'(i), 1'b0);
		@(negedge clk);
		entry_valid = 1'b1;
		@(negedge clk);
		cmp_flag(entry_ready, 1'b0);
		entry_valid = 1'b0;
		pop(16'h00B2, 1'b1);
		for (int i = 0; i < 7; i++) pop(16'h00C0 + 16'(i), 1'b0);
		pop(16'h00B2, 1'b1);
	endtask : s_store

	initial begin
		clk = 1'b0;
		reset = 1'b1;
		ce = 1'b1;
		ref_bit = 1'b0;
		sync_lost = 1'b0;
		power_lost = 1'b0;
		gate_start = 1'b0;
		gran_sel = BERA_GRAN_SEC;
		entry_valid = 1'b0;
		entry_perm = 1'b0;
		entry_code = 16'h0000;
		rd_ack = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		cmp_flag(gating, 1'b0);
		cmp_flag(rd_valid, 1'b0);
		repeat (30) @(negedge clk);
		cmp_flag(data_loss, 1'b1);
		s_store();
		s_errors();
		s_loss_seconds();
		end_of_test();
	end
endmodule : tb_top
